// ### logic/sysclk_prescaler_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - programmed clock-output fuse puts system clock on pin, overriding normal pin use
// - with that fuse programmed the clock also appears while reset is held
// - pin carries the divided system clock, not the undivided source; while reset is held it carries undivided hclk (code: pin stays high at divide by one)
// - one division factor drives cpu, io, adc and flash clocks alike
// - division changes produce no glitch or runt pulse on derived clocks
// - no intermediate rate exceeds old or new; counter runs on source clock
// - new rate active between T1+T2 and T1+2*T2 after write, two edges between
// - change-enable sets only when written one with all other bits zero
// - change-enable clears four cycles after set or when select is written
// - rewriting change-enable in its window neither restarts nor clears it
// - select resets to 0000, or 0011 with divide-by-eight fuse; later free
// - select codes 0000..1000 divide by 1..256 in powers of two; rest reserved
// - sleep entered only on sleep instruction with sleep-enable one; mode chosen by field
// - mode 000 idle, 001 adc noise, 010 power-down, 110 standby; others reserved
// - after wake the core stays halted start-up time plus four cycles
// - register file and sram contents survive sleep entry and wake
// - reset during sleep wakes device into reset-vector execution
// - idle stops only cpu and flash clocks; io and adc keep running
// - adc enabled at idle entry starts one conversion
module sysclk_prescaler_sleep_ctrl (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // fuses
  input  wire logic                  clock_output_fuse,
  input  wire logic                  divide_by_eight_fuse,
  // clock output pin
  input  wire logic                  gpio_out,
  input  wire logic                  gpio_oe,
  output logic                       clock_output_pin,
  output logic                       clock_output_pin_oe,
  // core and peripherals
  input  wire logic                  sleep_instr,
  input  wire logic                  wake_irq,
  input  wire logic                  adc_enabled,
  output sysclk_pkg::clk_en_t        clk_en,
  output logic                       sys_tick,
  output logic                       core_halt,
  output logic                       wake_resume,
  output logic                       adc_start_conv
);

  // ==========================================================
  // bus address and data phase
  logic        ap_valid;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_mux;
  logic        hit_prescale;
  logic        hit_sleep;
  logic        hit_status;
  logic        wr_prescale;
  logic        wr_sleep;

  assign ap_valid     = hsel & htrans[1] & hready;
  assign hit_prescale = haddr[11:0] == sysclk_pkg::PRESCALE_OFFSET;
  assign hit_sleep    = haddr[11:0] == sysclk_pkg::SLEEP_OFFSET;
  assign hit_status   = haddr[11:0] == sysclk_pkg::STATUS_OFFSET;
  assign wr_prescale  = wr_pend_reg & (wr_addr_reg == sysclk_pkg::PRESCALE_OFFSET);
  assign wr_sleep     = wr_pend_reg & (wr_addr_reg == sysclk_pkg::SLEEP_OFFSET);
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= sysclk_pkg::PRESCALE_OFFSET;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= ap_valid & hwrite;
      if (ap_valid) begin
        wr_addr_reg <= haddr[11:0];
      end
      if (ap_valid & ~hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ==========================================================
  // write data fields
  logic [6:0] wdata_low;
  logic [3:0] wdata_sel;
  logic [2:0] wdata_mode;
  logic       wdata_pce;
  logic       wdata_se;

  assign wdata_low  = hwdata[sysclk_pkg::PCE_BIT-1:0];
  assign wdata_sel  = hwdata[sysclk_pkg::SEL_LSB +: 4];
  assign wdata_mode = hwdata[sysclk_pkg::MODE_LSB +: 3];
  assign wdata_pce  = hwdata[sysclk_pkg::PCE_BIT];
  assign wdata_se   = hwdata[sysclk_pkg::SE_BIT];

  // ==========================================================
  // prescale control register
  logic       init_reg;
  logic       pce_reg;
  logic [2:0] win_cnt_reg;
  logic [3:0] sel_reg;
  logic [3:0] act_sel_reg;
  logic       switch_pend_reg;
  logic       pce_set;
  logic       sel_write;
  logic       win_end;
  logic [3:0] fuse_sel;
  logic [3:0] sel_clamped;

  assign pce_set   = wr_prescale & wdata_pce
                   & (wdata_low == sysclk_pkg::PCE_OTHERS_Z);
  assign sel_write = wr_prescale & ~wdata_pce & pce_reg;
  assign win_end   = pce_reg & (win_cnt_reg == sysclk_pkg::WINDOW_LAST);
  assign fuse_sel  = divide_by_eight_fuse ? sysclk_pkg::SEL_DIV8
                                          : sysclk_pkg::SEL_RESET;
  assign sel_clamped = (sel_reg > sysclk_pkg::SEL_MAX) ? sysclk_pkg::SEL_MAX
                                                       : sel_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pce_reg     <= 1'b0;
      win_cnt_reg <= 3'h0;
    end else if (sel_write | win_end) begin
      pce_reg     <= 1'b0;
      win_cnt_reg <= 3'h0;
    end else if (pce_reg) begin
      win_cnt_reg <= 3'(win_cnt_reg + 3'h1);
    end else if (pce_set) begin
      pce_reg     <= 1'b1;
      win_cnt_reg <= 3'h0;
    end
  end

  // ==========================================================
  // synchronous counter divider on the undivided source clock
  logic [7:0] cnt_reg;
  logic [8:0] one_hot;
  logic [7:0] mask;
  logic       tick;
  logic       clk_out_reg;

  assign one_hot = sysclk_pkg::HOT_ONE << act_sel_reg;
  assign mask    = 8'(one_hot[7:0] - sysclk_pkg::CNT_ONE);
  assign tick    = (cnt_reg & mask) == mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= sysclk_pkg::CNT_ZERO;
    end else if (tick) begin
      cnt_reg <= sysclk_pkg::CNT_ZERO;
    end else begin
      cnt_reg <= 8'(cnt_reg + sysclk_pkg::CNT_ONE);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_reg        <= 1'b1;
      sel_reg         <= sysclk_pkg::SEL_RESET;
      act_sel_reg     <= sysclk_pkg::SEL_RESET;
      switch_pend_reg <= 1'b0;
    end else if (init_reg) begin
      init_reg        <= 1'b0;
      sel_reg         <= fuse_sel;
      act_sel_reg     <= fuse_sel;
    end else begin
      if (sel_write) begin
        sel_reg <= wdata_sel;
      end
      if (tick & switch_pend_reg) begin
        act_sel_reg <= sel_clamped;
      end
      if (sel_write) begin
        switch_pend_reg <= 1'b1;
      end else if (tick) begin
        switch_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out_reg <= 1'b0;
    end else begin
      clk_out_reg <= tick;
    end
  end

  // ==========================================================
  // clock output pin
  logic pin_clock;

  assign pin_clock           = hresetn ? clk_out_reg : hclk;
  assign clock_output_pin    = clock_output_fuse ? pin_clock : gpio_out;
  assign clock_output_pin_oe = clock_output_fuse | gpio_oe;

  // ==========================================================
  // sleep mode control register
  logic       se_reg;
  logic [2:0] sm_reg;
  logic       mode_valid;

  assign mode_valid = (sm_reg == sysclk_pkg::MODE_IDLE)
                    | (sm_reg == sysclk_pkg::MODE_ADC_NR)
                    | (sm_reg == sysclk_pkg::MODE_PDOWN)
                    | (sm_reg == sysclk_pkg::MODE_STANDBY);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      se_reg <= sysclk_pkg::SLEEP_RESET[sysclk_pkg::SE_BIT];
      sm_reg <= sysclk_pkg::SLEEP_RESET[sysclk_pkg::MODE_LSB +: 3];
    end else if (wr_sleep) begin
      se_reg <= wdata_se;
      sm_reg <= wdata_mode;
    end
  end

  // ==========================================================
  // sleep state machine
  sysclk_pkg::sleep_state_t state_reg;
  sysclk_pkg::sleep_state_t state_next;
  sysclk_pkg::sleep_mode_t  mode_reg;
  logic [7:0]               wake_cnt_reg;
  logic [7:0]               wake_target;
  logic                     enter;
  logic                     wake_done;
  logic                     adc_start_reg;
  logic                     resume_reg;

  assign enter = sleep_instr & se_reg & mode_valid;

  always_comb begin
    case (mode_reg)
      sysclk_pkg::MODE_STANDBY: wake_target = 8'(sysclk_pkg::STANDBY_STARTUP
                                               + sysclk_pkg::WAKE_EXTRA);
      sysclk_pkg::MODE_PDOWN:   wake_target = 8'(sysclk_pkg::PDOWN_STARTUP
                                               + sysclk_pkg::WAKE_EXTRA);
      default:                  wake_target = 8'(sysclk_pkg::IDLE_STARTUP
                                               + sysclk_pkg::WAKE_EXTRA);
    endcase
  end

  assign wake_done = tick & (wake_cnt_reg == 8'(wake_target - 8'h01));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sysclk_pkg::ST_RUN: begin
        if (enter) begin
          state_next = sysclk_pkg::ST_ASLEEP;
        end
      end
      sysclk_pkg::ST_ASLEEP: begin
        if (wake_irq) begin
          state_next = sysclk_pkg::ST_WAKING;
        end
      end
      sysclk_pkg::ST_WAKING: begin
        if (wake_done) begin
          state_next = sysclk_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = sysclk_pkg::ST_RUN;
      end
    endcase
  end

  // reset from any state lands in run, the core restarts from its reset vector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= sysclk_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= sysclk_pkg::MODE_IDLE;
    end else if ((state_reg == sysclk_pkg::ST_RUN) & enter) begin
      mode_reg <= sysclk_pkg::sleep_mode_t'(sm_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cnt_reg <= 8'h00;
    end else if (state_reg != sysclk_pkg::ST_WAKING) begin
      wake_cnt_reg <= 8'h00;
    end else if (tick) begin
      wake_cnt_reg <= 8'(wake_cnt_reg + 8'h01);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_start_reg <= 1'b0;
      resume_reg    <= 1'b0;
    end else begin
      adc_start_reg <= (state_reg == sysclk_pkg::ST_RUN) & enter & adc_enabled
                     & ((sm_reg == sysclk_pkg::MODE_IDLE)
                      | (sm_reg == sysclk_pkg::MODE_ADC_NR));
      resume_reg    <= (state_reg == sysclk_pkg::ST_WAKING) & wake_done;
    end
  end

  // ==========================================================
  // clock gating per state and mode
  logic asleep;
  logic halted;
  logic io_off;
  logic adc_off;

  assign asleep  = state_reg == sysclk_pkg::ST_ASLEEP;
  assign halted  = state_reg != sysclk_pkg::ST_RUN;
  assign io_off  = asleep & (mode_reg != sysclk_pkg::MODE_IDLE);
  assign adc_off = asleep & (mode_reg != sysclk_pkg::MODE_IDLE)
                          & (mode_reg != sysclk_pkg::MODE_ADC_NR);

  // gating only, no core state is cleared by sleep
  assign clk_en.cpu   = tick & ~halted;
  assign clk_en.flash = tick & ~halted;
  assign clk_en.io    = tick & ~io_off;
  assign clk_en.adc   = tick & ~adc_off;
  assign sys_tick       = tick;
  assign core_halt      = halted;
  assign wake_resume    = resume_reg;
  assign adc_start_conv = adc_start_reg;

  // ==========================================================
  // read mux
  logic [31:0] rd_prescale;
  logic [31:0] rd_sleep;
  logic [31:0] rd_status;

  assign rd_prescale = {24'h000000, pce_reg, 3'h0, sel_reg};
  assign rd_sleep    = {28'h0000000, sm_reg, se_reg};
  always_comb begin
    rd_status                                   = 32'h0000_0000;
    rd_status[sysclk_pkg::STAT_SEL_LSB +: 4]    = act_sel_reg;
    rd_status[sysclk_pkg::STAT_PEND_BIT]        = switch_pend_reg;
    rd_status[sysclk_pkg::STAT_PCE_BIT]         = pce_reg;
    rd_status[sysclk_pkg::STAT_ST_LSB +: 2]     = state_reg;
    rd_status[sysclk_pkg::STAT_MODE_LSB +: 3]   = mode_reg;
  end
  assign rd_mux      = hit_prescale ? rd_prescale :
                       hit_sleep    ? rd_sleep    :
                       hit_status   ? rd_status   : 32'h0000_0000;

  logic unused_ok;
  assign unused_ok = &{1'b0, haddr[31:12], hsize, hwdata[31:8], htrans[0]};

endmodule
`default_nettype wire

// ### logic/sysclk_pkg.sv
`default_nettype none
package sysclk_pkg;

  // ==========================================================
  // register map (word aligned byte addresses)
  localparam logic [11:0] PRESCALE_OFFSET = 12'h000;
  localparam logic [11:0] SLEEP_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET   = 12'h008;

  // ==========================================================
  // prescale control fields
  localparam int          PCE_BIT      = 7;
  localparam int          SEL_LSB      = 0;
  localparam logic [6:0]  PCE_OTHERS_Z = 7'h00;
  localparam logic [3:0]  SEL_RESET    = 4'h0;
  localparam logic [3:0]  SEL_DIV8     = 4'h3;
  localparam logic [3:0]  SEL_MAX      = 4'h8;
  localparam logic [2:0]  WINDOW_LAST  = 3'h3;

  // ==========================================================
  // sleep control fields
  localparam int         SE_BIT       = 0;
  localparam int         MODE_LSB     = 1;
  localparam logic [7:0] SLEEP_RESET  = 8'h00;

  // ==========================================================
  // status fields
  localparam int STAT_SEL_LSB  = 0;
  localparam int STAT_PEND_BIT = 4;
  localparam int STAT_PCE_BIT  = 5;
  localparam int STAT_ST_LSB   = 6;
  localparam int STAT_MODE_LSB = 8;

  // ==========================================================
  // divider constants
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE  = 8'h01;
  localparam logic [8:0] HOT_ONE  = 9'h001;

  // ==========================================================
  // wake timing, in system clock ticks
  localparam logic [7:0] WAKE_EXTRA       = 8'h04;
  localparam logic [7:0] STANDBY_STARTUP  = 8'h06;
  localparam logic [7:0] PDOWN_STARTUP    = 8'h06;
  localparam logic [7:0] IDLE_STARTUP     = 8'h00;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    MODE_IDLE    = 3'b000,
    MODE_ADC_NR  = 3'b001,
    MODE_PDOWN   = 3'b010,
    MODE_STANDBY = 3'b110
  } sleep_mode_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_ASLEEP = 2'b01,
    ST_WAKING = 2'b10
  } sleep_state_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
  } clk_en_t;

endpackage
`default_nettype wire

// ### tb/sysclk_props.sv
`timescale 1ns/1ps
`default_nettype none
module sysclk_props (
  // clock and reset
  input wire logic                hclk,
  input wire logic                hresetn,
  // pin
  input wire logic                clock_output_fuse,
  input wire logic                gpio_out,
  input wire logic                gpio_oe,
  input wire logic                clock_output_pin,
  input wire logic                clock_output_pin_oe,
  // core side
  input wire logic                sleep_instr,
  input wire logic                wake_irq,
  input wire sysclk_pkg::clk_en_t clk_en,
  input wire logic                sys_tick,
  input wire logic                core_halt,
  input wire logic                wake_resume,
  input wire logic                adc_start_conv
);
  // ==================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pin_gpio_pass: assert property (!clock_output_fuse |-> clock_output_pin == gpio_out)
    else $error("pin does not follow gpio");
  a_pin_oe_select: assert property (clock_output_pin_oe == (clock_output_fuse | gpio_oe))
    else $error("pin enable wrong");
  a_run_clocks_equal: assert property (!core_halt |-> clk_en == {4{sys_tick}})
    else $error("clock enables differ while running");
  a_halt_gates_cpu: assert property (core_halt |-> !clk_en.cpu && !clk_en.flash)
    else $error("cpu or flash clock runs while halted");
  a_halt_needs_sleep: assert property ($rose(core_halt) |-> $past(sleep_instr))
    else $error("halt without sleep instruction");
  a_wake_hold: assert property ($rose(wake_irq) && core_halt |-> core_halt [*5])
    else $error("halt too short after wake");
  a_resume_after_wake: assert property ($fell(core_halt) |-> ##[0:1] wake_resume)
    else $error("no resume after wake");
  a_resume_single: assert property (wake_resume |-> !core_halt ##1 !wake_resume)
    else $error("resume pulse wrong");
  a_adc_on_entry: assert property (adc_start_conv |-> core_halt ##1 !adc_start_conv)
    else $error("conversion start outside entry");
endmodule
bind sysclk_prescaler_sleep_ctrl sysclk_props u_props (.hclk, .hresetn, .clock_output_fuse,
  .gpio_out, .gpio_oe, .clock_output_pin, .clock_output_pin_oe, .sleep_instr, .wake_irq,
  .clk_en, .sys_tick, .core_halt, .wake_resume, .adc_start_conv);
`default_nettype wire

// ### tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock
  input  wire logic hclk,
  // block status
  input  wire logic core_halt,
  input  wire logic wake_resume,
  // requests
  output logic      sleep_instr,
  output logic      wake_irq
);
  initial begin
    sleep_instr = 1'h0;
    wake_irq = 1'h0;
  end
  // one-cycle sleep instruction
  task automatic do_sleep();
    sleep_instr <= 1'h1;
    @(posedge hclk);
    sleep_instr <= 1'h0;
  endtask
  // interrupt held until resume, cycles counted
  task automatic wake(output int n);
    n = 0;
    wake_irq <= 1'h1;
    do begin
      @(posedge hclk);
      n++;
    end while ((core_halt || !wake_resume) && n < 100);
    wake_irq <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==================
  // signals
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]         haddr, hwdata, hrdata, q;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic                clock_output_fuse, divide_by_eight_fuse, gpio_out, gpio_oe;
  logic                clock_output_pin, clock_output_pin_oe, sleep_instr, wake_irq;
  logic                adc_enabled, sys_tick, core_halt, wake_resume, adc_start_conv;
  sysclk_pkg::clk_en_t clk_en;
  logic [31:0]         exp_q[$], got_q[$];
  string               nm_q[$];
  int                  error_cnt, compares, cyc, n, k, cur, nconv, nres;
  event                res_ev;
  assign hready = hreadyout;
  sysclk_prescaler_sleep_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .clock_output_fuse, .divide_by_eight_fuse,
    .gpio_out, .gpio_oe, .clock_output_pin, .clock_output_pin_oe, .sleep_instr, .wake_irq,
    .adc_enabled, .clk_en, .sys_tick, .core_halt, .wake_resume, .adc_start_conv);
  core_model u_core (.hclk, .core_halt, .wake_resume, .sleep_instr, .wake_irq);
  initial begin
    hclk = 1'h0;
    forever #50 hclk = ~hclk;
  end
  always @(negedge hclk) begin
    cyc++;
    nconv += adc_start_conv;
    nres += wake_resume;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end
  always @(posedge hclk) {gpio_oe, gpio_out} <= 2'($urandom);
  // ==================
  // result handling
  task automatic stop_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask
  task automatic post(input string nm, input logic [31:0] e, input logic [31:0] g);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    got_q.push_back(g);
    -> res_ev;
  endtask
  initial forever begin
    @(res_ev);
    while (got_q.size() > 0) chk(nm_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
  end
  // ==================
  // drivers
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic rdx(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    post(nm, e, q);
    post("response", 0, hresp);
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    do @(posedge hclk); while (!sys_tick);
    do begin
      @(posedge hclk);
      g++;
    end while (!sys_tick && g < 600);
  endtask
  task automatic set_div(input logic [3:0] c);
    int t2;
    t2 = (c > 4'h8) ? 256 : (1 << c);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h80);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, {28'h0, c});
    n = 0;
    k = 0;
    while (k < 2) begin
      @(posedge hclk);
      n++;
      k += sys_tick;
    end
    post("switch time", 1, n <= cur + 2 * t2);
    tick_gap(k);
    post("divided period", t2, k);
    rdx("select", sysclk_pkg::PRESCALE_OFFSET, {28'h0, c});
    cur = t2;
  endtask
  task automatic nap(input logic [2:0] m, input logic se);
    logic ok;
    logic [3:0] en;
    int c0;
    ok = se && (m inside {3'h0, 3'h1, 3'h2, 3'h6});
    en = (m == 3'h0) ? 4'h3 : (m == 3'h1) ? 4'h1 : 4'h0;
    adc_enabled <= 1'($urandom);
    bus(1'h1, sysclk_pkg::SLEEP_OFFSET, {28'h0, m, se});
    c0 = nconv;
    u_core.do_sleep();
    repeat (2) @(posedge hclk);
    post("halted", ok, core_halt);
    post("clock enables", ok ? en : 4'hF, {28'h0, clk_en});
    post("conversions", ok && !m[1] && adc_enabled, nconv - c0);
    if (ok) begin
      rdx("status", sysclk_pkg::STATUS_OFFSET, {21'h0, m, 2'h1, 6'h0});
      u_core.wake(n);
      post("wake span", 1, n >= (m[1] ? 10 : 4) && n <= (m[1] ? 13 : 7));
    end
    bus(1'h1, sysclk_pkg::SLEEP_OFFSET, 32'h0);
  endtask
  // ==================
  // tests
  initial begin
    k = $urandom(32'hBAA6D1B0);
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    adc_enabled = 1'h0;
    clock_output_fuse = 1'h1;
    divide_by_eight_fuse = 1'h1;
    @(posedge hclk);
    #25 post("pin in reset", 1, clock_output_pin);
    @(negedge hclk);
    #25 post("pin in reset", 0, clock_output_pin);
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    rdx("reset select", sysclk_pkg::PRESCALE_OFFSET, 32'h3);
    rdx("sleep reset", sysclk_pkg::SLEEP_OFFSET, 32'h0);
    tick_gap(k);
    post("reset period", 8, k);
    k = 0;
    repeat (32) begin
      @(posedge hclk);
      k += clock_output_pin;
    end
    post("pin pulses", 4, k);
    post("pin enable fuse", 1, clock_output_pin_oe);
    clock_output_fuse <= 1'h0;
    @(negedge hclk);
    post("gpio pass", gpio_out, clock_output_pin);
    post("pin enable", gpio_oe, clock_output_pin_oe);
    @(posedge hclk);
    bus(1'h1, 12'h010, 32'hFFFFFFFF);
    rdx("unmapped", 12'h010, 32'h0);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h81);
    rdx("locked write", sysclk_pkg::PRESCALE_OFFSET, 32'h3);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h80);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h80);
    rdx("window open", sysclk_pkg::PRESCALE_OFFSET, 32'h83);
    rdx("window shut", sysclk_pkg::PRESCALE_OFFSET, 32'h3);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h2);
    rdx("late select", sysclk_pkg::PRESCALE_OFFSET, 32'h3);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h80);
    bus(1'h1, sysclk_pkg::PRESCALE_OFFSET, 32'h5);
    rdx("select clears", sysclk_pkg::PRESCALE_OFFSET, 32'h5);
    cur = 32;
    for (int c = 0; c < 9; c++) set_div(c[3:0]);
    k = 9 + $urandom % 7;
    set_div(k[3:0]);
    set_div(4'h0);
    for (int m = 0; m < 8; m++) nap(m[2:0], 1'h1);
    nap(3'h0, 1'h0);
    divide_by_eight_fuse <= 1'h0;
    bus(1'h1, sysclk_pkg::SLEEP_OFFSET, 32'h5);
    u_core.do_sleep();
    k = nres;
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    post("halt after reset", 0, core_halt);
    post("resume count", k, nres);
    rdx("sleep after reset", sysclk_pkg::SLEEP_OFFSET, 32'h0);
    rdx("fuse clear select", sysclk_pkg::PRESCALE_OFFSET, 32'h0);
    repeat (2) @(posedge hclk);
    stop_test();
  end
endmodule
`default_nettype wire
